// >>> hdl/psop_top.v
`timescale 1ns/1ps
`include "psop_map.vh"
module psop_top (
    input  wire        MCLK,
    input  wire        RST,
    input  wire [7:0]  SAMPLE_IN,
    input  wire        OE_N,
    input  wire        PWRDN,
    output wire [7:0]  DATA_O,
    output wire [7:0]  DATA_OE_N,
    output wire        POWERED,
    output wire        DATA_VALID
);
    localparam LAT = `PSOP_LATENCY;
    localparam W   = `PSOP_DATA_W;

    reg  [W-1:0]  pipe_r [0:LAT-2];  // Latency line; the bus register is the last stage
    reg  [LAT-2:0] vld_r;            // Valid marks along the line
    reg  [1:0]    st_r;              // Power state
    reg  [1:0]    st_nxt;
    reg  [2:0]    cnt_r;             // Transition timer
    reg  [2:0]    cnt_nxt;
    reg  [W-1:0]  out_r;             // Bus word register
    reg           dv_r;              // Registered word valid
    wire          run;               // Sampling active
    wire          run_nxt;           // Sampling active after this edge
    wire [W-1:0]  f_data;            // FIFO head
    wire          f_valid;           // FIFO holds a word
    wire          f_ready;           // FIFO accepts a word

    // Samples are flagged valid only in the run state
    assign run = (st_r == `PSOP_ST_RUN);
    // Looks one edge ahead so no word is flagged once power-down starts
    assign run_nxt = (st_nxt == `PSOP_ST_RUN);

    // Offset binary maps input codes straight through
    function [W-1:0] psop_code;
        input [W-1:0] s;
        begin
            psop_code = s;
        end
    endfunction

    // Power state next value
    always @*
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            `PSOP_ST_RUN:
            begin
                // Low power-down input starts entry
                if (!PWRDN)
                begin
                    st_nxt  = `PSOP_ST_ENTER;
                    cnt_nxt = 3'h0;
                end
            end
            `PSOP_ST_ENTER:
            begin
                // Count up to the entry time, then low-power state
                if (cnt_r == `PSOP_PD_ENTER_CYC - 1)
                    st_nxt = `PSOP_ST_DOWN;
                else
                    cnt_nxt = cnt_r + 3'h1;
            end
            `PSOP_ST_DOWN:
            begin
                // High input starts exit
                if (PWRDN)
                begin
                    st_nxt  = `PSOP_ST_EXIT;
                    cnt_nxt = 3'h0;
                end
            end
            `PSOP_ST_EXIT:
            begin
                // Resume after exit time
                if (cnt_r == `PSOP_PD_EXIT_CYC - 1)
                    st_nxt = `PSOP_ST_RUN;
                else
                    cnt_nxt = cnt_r + 3'h1;
            end
            default:
            begin
                st_nxt  = `PSOP_ST_RUN;
                cnt_nxt = 3'h0;
            end
        endcase
    end

    // Power state register
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            st_r  <= `PSOP_ST_RUN;
            cnt_r <= 3'h0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // First stage samples the input on every edge
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            pipe_r[0] <= {W{1'b0}};
            vld_r[0]  <= 1'b0;
        end
        else
        begin
            pipe_r[0] <= psop_code(SAMPLE_IN);
            vld_r[0]  <= run;
        end
    end

    // Remaining stages shift once per clock
    genvar g;
    generate
        for (g = 1; g < LAT - 1; g = g + 1)
        begin : stg
            always @(posedge MCLK or posedge RST)
            begin
                if (RST)
                begin
                    pipe_r[g] <= {W{1'b0}};
                    vld_r[g]  <= 1'b0;
                end
                else
                begin
                    pipe_r[g] <= pipe_r[g-1];
                    vld_r[g]  <= vld_r[g-1] & run;
                end
            end
        end
    endgenerate

    // Buffer between pipeline tail and bus register
    psop_fifo #(
        .W  (W),
        .D  (`PSOP_FIFO_DEPTH),
        .AW (`PSOP_FIFO_AW)
    ) u_fifo (
        .MCLK      (MCLK),
        .RST       (RST),
        .IN_DATA   (pipe_r[LAT-2]),
        .IN_VALID  (vld_r[LAT-2] & run),
        .IN_READY  (f_ready),
        .OUT_DATA  (f_data),
        .OUT_VALID (f_valid),
        .OUT_READY (1'b1)
    );

    // Bus register: word lands five edges after its sample
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            out_r  <= {W{1'b0}};
            dv_r   <= 1'b0;
        end
        else
        begin
            if (f_valid)
                out_r <= f_data;
            // Words still in flight when power-down starts are not flagged
            dv_r   <= f_valid & f_ready & run_nxt;
        end
    end

    // Bit 7 of the port is the most significant bit
    assign DATA_O     = out_r;
    // Enable is low while driving; all bits float together
    assign DATA_OE_N  = {W{OE_N}};
    assign POWERED    = run;
    assign DATA_VALID = dv_r;
endmodule

// >>> hdl/psop_map.vh
`ifndef PSOP_MAP_VH
`define PSOP_MAP_VH
// Sample word width
`define PSOP_DATA_W       8
// Pipeline latency in convert clock cycles
`define PSOP_LATENCY      5
// Output FIFO depth in words and its pointer width
`define PSOP_FIFO_DEPTH   32
`define PSOP_FIFO_AW      5
// Clock period in ns
`define PSOP_CLK_NS       25
// Power-down entry and exit times in ns
`define PSOP_PD_ENTER_NS  133
`define PSOP_PD_EXIT_NS   18
// Entry is a longest time (rounded down), exit a least time (rounded up)
`define PSOP_PD_ENTER_CYC (`PSOP_PD_ENTER_NS / `PSOP_CLK_NS)
`define PSOP_PD_EXIT_CYC  ((`PSOP_PD_EXIT_NS + `PSOP_CLK_NS - 1) / `PSOP_CLK_NS)
// Power state codes
`define PSOP_ST_RUN       2'h0
`define PSOP_ST_ENTER     2'h1
`define PSOP_ST_DOWN      2'h2
`define PSOP_ST_EXIT      2'h3
`endif

// >>> hdl/psop_fifo.v
`timescale 1ns/1ps
// Synchronous FIFO with valid/ready on both sides
module psop_fifo #(
    parameter W  = 8,
    parameter D  = 32,
    parameter AW = 5
) (
    input  wire          MCLK,
    input  wire          RST,
    input  wire [W-1:0]  IN_DATA,
    input  wire          IN_VALID,
    output wire          IN_READY,
    output wire [W-1:0]  OUT_DATA,
    output wire          OUT_VALID,
    input  wire          OUT_READY
);
    reg  [W-1:0]  mem [0:D-1];   // Storage
    reg  [AW:0]   wp_r;          // Write pointer with wrap bit
    reg  [AW:0]   rp_r;          // Read pointer with wrap bit
    wire          full;          // No free slot
    wire          empty;         // No word held
    wire          wr;            // Write this cycle
    wire          rd;            // Read this cycle

    assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty     = (wp_r == rp_r);
    assign IN_READY  = ~full;
    assign OUT_VALID = ~empty;
    assign OUT_DATA  = mem[rp_r[AW-1:0]];
    assign wr        = IN_VALID & ~full;
    assign rd        = OUT_READY & ~empty;

    // Storage write
    always @(posedge MCLK)
    begin
        if (wr)
            mem[wp_r[AW-1:0]] <= IN_DATA;
    end

    // Pointer update
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (wr)
                wp_r <= wp_r + 1'b1;
            if (rd)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule

// >>> sim/psop_chk_sva.sv
`timescale 1ns/1ps
// Checks latency, enables and power states at the top ports
module psop_chk (
    input wire       MCLK,
    input wire       RST,
    input wire [7:0] SAMPLE_IN,
    input wire       OE_N,
    input wire       PWRDN,
    input wire [7:0] DATA_O,
    input wire [7:0] DATA_OE_N,
    input wire       POWERED,
    input wire       DATA_VALID
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_LAT: assert property (DATA_VALID |-> DATA_O == $past(SAMPLE_IN, 6))
        else $error("word not five edges late");
    AST_OE_ON: assert property (!OE_N |-> DATA_OE_N == 8'h00)
        else $error("bus not driven");
    AST_OE_OFF: assert property (OE_N |-> DATA_OE_N == 8'hff)
        else $error("bus not floated");
    AST_PD_IN: assert property ($fell(PWRDN) |-> ##[1:6] !POWERED)
        else $error("slow power-down entry");
    AST_PD_OUT: assert property ($rose(PWRDN) |-> ##[1:3] POWERED)
        else $error("slow power-down exit");
    AST_DOWN: assert property (!POWERED |-> !DATA_VALID)
        else $error("valid while down");
    AST_WARM: assert property ($rose(POWERED) |-> !DATA_VALID [*6])
        else $error("early word after wake");
    AST_RATE: assert property (POWERED [*8] |-> DATA_VALID)
        else $error("gap in output stream");
endmodule
bind psop_top psop_chk u_psop_chk (.MCLK(MCLK), .RST(RST), .SAMPLE_IN(SAMPLE_IN),
    .OE_N(OE_N), .PWRDN(PWRDN), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N),
    .POWERED(POWERED), .DATA_VALID(DATA_VALID));

// >>> sim/psop_cap.sv
`timescale 1ns/1ps
// Capture side: registers the bus once a clock while it is driven and the word is flagged valid
module psop_cap (
    input  wire        mclk,
    input  wire [7:0]  bus,
    input  wire        oe_n,
    input  wire        valid,
    output reg  [7:0]  word_r,
    output reg  [15:0] cnt_r
);
    initial word_r = 8'h00;
    initial cnt_r = 16'h0000;
    // Flagged words only, so warm-up words are dropped
    always @(posedge mclk)
    begin
        if (!oe_n && valid)
        begin
            word_r <= bus;
            cnt_r  <= cnt_r + 16'h0001;
        end
    end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg         mclk = 1'b0;
    reg         rst = 1'b1;
    reg  [7:0]  sample_in = 8'h00;
    reg         oe_n = 1'b0;
    reg         pwrdn = 1'b1;
    wire [7:0]  data_o;
    wire [7:0]  data_oe_n;
    wire        powered;
    wire        data_valid;
    wire [7:0]  cap_word;
    wire [15:0] cap_cnt;
    // A floated bus shows the inverse of the last word
    wire [7:0]  bus = (data_oe_n == 8'h00) ? data_o : ~data_o;
    reg  [47:0] hist = 48'h0;
    reg  [7:0]  lfsr = 8'h20;
    reg  [31:0] corners = 32'h00ff807f;
    reg  [15:0] cnt_base = 16'h0000;
    integer     err_count = 0;
    integer     samples_checked = 0;
    integer     i;
    always #12.5 mclk = ~mclk;
    psop_top u_psop_top (.MCLK(mclk), .RST(rst), .SAMPLE_IN(sample_in), .OE_N(oe_n),
        .PWRDN(pwrdn), .DATA_O(data_o), .DATA_OE_N(data_oe_n), .POWERED(powered),
        .DATA_VALID(data_valid));
    psop_cap u_psop_cap (.mclk(mclk), .bus(bus), .oe_n(oe_n), .valid(data_valid),
        .word_r(cap_word), .cnt_r(cap_cnt));
    // Next pseudo-random value
    function [7:0] lfsr_next(input [7:0] v);
        lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Straight offset binary: lowest step is all zeros, highest all ones
    function [7:0] exp_code(input [7:0] s);
        exp_code = s;
    endfunction
    task chk8(input [7:0] got, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task chk1(input got, input exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask
    task complete_run;
    begin
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // Sample history: top slot is the word due now
    always @(posedge mclk) hist <= {hist[39:0], sample_in};
    // Enable copy and delayed word, checked mid-cycle
    always @(negedge mclk)
    begin
        if (!rst)
        begin
            chk8(data_oe_n, {8{oe_n}});
            if (data_valid === 1'b1)
                chk8(data_o, exp_code(hist[47:40]));
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        // Random words with random bus enable
        for (i = 0; i < 300; i = i + 1)
        begin
            @(posedge mclk);
            lfsr = lfsr_next(lfsr);
            sample_in <= lfsr;
            oe_n <= lfsr[0] & lfsr[3];
        end
        $display("test random done");
        // Code extremes and the mid-scale pair back to back, bus driven
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge mclk);
            sample_in <= corners[31 - 8 * i -: 8];
            oe_n <= 1'b0;
        end
        // Each extreme reaches the capture register one edge after the bus
        repeat (4) @(posedge mclk);
        for (i = 0; i < 4; i = i + 1)
        begin
            #1 chk8(cap_word, exp_code(corners[31 - 8 * i -: 8]));
            if (i == 0)
                cnt_base = cap_cnt;
            @(posedge mclk);
        end
        #1 cnt_base = cap_cnt - cnt_base;
        chk8(cnt_base[7:0], 8'h04);
        $display("test codes done");
        // Power-down, then wake and warm up
        @(posedge mclk) pwrdn <= 1'b0;
        repeat (12) @(posedge mclk);
        #1 chk1(powered, 1'b0);
        chk1(data_valid, 1'b0);
        @(posedge mclk) pwrdn <= 1'b1;
        for (i = 0; i < 8 && powered !== 1'b1; i = i + 1)
        begin
            @(posedge mclk);
            #1;
        end
        chk1(powered, 1'b1);
        chk8(i[7:0], 8'h02);
        repeat (10) @(posedge mclk);
        #1 chk1(data_valid, 1'b1);
        $display("test power done");
        complete_run;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count = err_count + 1;
        complete_run;
    end
endmodule
